// *** verilog/pmsa_pkg.sv ***
// Package for the one-second performance monitor register slice.
// Assumes an 8-bit register address space and byte-wide registers.
package pmsa_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_TXV_HIGH  = 8'h3A;
    localparam logic [7:0] ADDR_TXV_LOW   = 8'h3B;
    localparam logic [7:0] ADDR_HOLD      = 8'h3C;
    localparam logic [7:0] ADDR_FLAGS     = 8'h3D;
    localparam logic [7:0] ADDR_LCV_HIGH  = 8'h3E;
    localparam logic [7:0] ADDR_LCV_LOW   = 8'h3F;
    localparam logic [7:0] ADDR_PBIT_HIGH = 8'h40;
    localparam logic [7:0] ADDR_PBIT_LOW  = 8'h41;

    // Field positions in second_error_flags
    localparam int FLAG_ES_BIT  = 1;
    localparam int FLAG_SES_BIT = 0;

    // Values after reset
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_DATA  = 16'h0000;

    // Severe errored second threshold: errors per second above bit rate / ratio
    localparam int          DS3_BIT_RATE  = 44736000;
    localparam int          SES_RATIO     = 10000;
    localparam logic [16:0] SES_ERR_LIMIT = 17'(DS3_BIT_RATE / SES_RATIO);

    typedef enum logic [2:0]
    {
        SEL_NONE,
        SEL_TXV,
        SEL_HOLD,
        SEL_FLAGS,
        SEL_LCV,
        SEL_PBIT
    } pmsa_sel_type;

endpackage

// *** verilog/pmsa_sat_cnt.sv ***
// Saturating event counter with a restart that keeps a coincident event.
// Assumes inc and restart are single-cycle strobes on sys_clk.
`timescale 1ns/1ps
module pmsa_sat_cnt
    import pmsa_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             inc,
    input  wire logic             restart,
    output logic      [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        count_nxt = count_r;
        if (restart)
        begin
            // Event in the restart cycle counts toward the new period
            count_nxt = inc ? WIDTH'(1) : '0;
        end
        else if (inc && !(&count_r))
        begin
            // Saturate rather than wrap so a flood never reads as small
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign count = count_r;

endmodule

// *** verilog/pmsa_regs.sv ***
// One-second accumulators, error-second flags and transmit valid cell count.
// Assumes bus and event inputs are synchronous to sys_clk from local logic;
// one_sec_tick is a one-cycle strobe from an external timebase.
`timescale 1ns/1ps
module pmsa_regs
    import pmsa_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wide16,
    input  wire logic        atm_uni_mode,
    input  wire logic        tx_valid_cell,
    input  wire logic        lcv_event,
    input  wire logic        pbit_error,
    input  wire logic        one_sec_tick,
    output logic      [15:0] rd_data,
    output logic             rd_valid
);

    logic [15:0]  txv_cnt;
    logic [15:0]  lcv_run;
    logic [15:0]  pbit_run;
    logic         txv_inc;
    logic         txv_clr;
    logic [16:0]  err_total;
    pmsa_sel_type sel;
    logic         hi_sel;
    logic [15:0]  sel_val;

    logic [15:0]  lcv_acc_r;
    logic [15:0]  lcv_acc_nxt;
    logic [15:0]  pbit_acc_r;
    logic [15:0]  pbit_acc_nxt;
    logic         es_r;
    logic         es_nxt;
    logic         ses_r;
    logic         ses_nxt;
    logic [7:0]   hold_r;
    logic [7:0]   hold_nxt;
    logic [15:0]  rd_data_r;
    logic [15:0]  rd_data_nxt;
    logic         rd_valid_r;
    logic         rd_valid_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Running counters

    assign txv_inc = tx_valid_cell && atm_uni_mode;
    assign txv_clr = bus_rd && (sel == SEL_TXV);

    pmsa_sat_cnt #(.WIDTH(16)) u_txv_cnt
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (txv_inc),
        .restart (txv_clr),
        .count   (txv_cnt)
    );

    pmsa_sat_cnt #(.WIDTH(16)) u_lcv_run
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (lcv_event),
        .restart (one_sec_tick),
        .count   (lcv_run)
    );

    pmsa_sat_cnt #(.WIDTH(16)) u_pbit_run
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .inc     (pbit_error),
        .restart (one_sec_tick),
        .count   (pbit_run)
    );

    ////////////////////////////////////////////////////////////////////////
    // One-second snapshot

    assign err_total = {1'b0, lcv_run} + {1'b0, pbit_run};

    always_comb
    begin
        lcv_acc_nxt  = lcv_acc_r;
        pbit_acc_nxt = pbit_acc_r;
        es_nxt       = es_r;
        ses_nxt      = ses_r;
        // Reads never touch these; only the boundary reloads them
        if (one_sec_tick)
        begin
            lcv_acc_nxt  = lcv_run;
            pbit_acc_nxt = pbit_run;
            es_nxt       = (err_total != 17'h00000);
            ses_nxt      = (err_total > SES_ERR_LIMIT);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            lcv_acc_r  <= RST_COUNT;
            pbit_acc_r <= RST_COUNT;
            es_r       <= 1'b0;
            ses_r      <= 1'b0;
        end
        else
        begin
            lcv_acc_r  <= lcv_acc_nxt;
            pbit_acc_r <= pbit_acc_nxt;
            es_r       <= es_nxt;
            ses_r      <= ses_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode and data path

    always_comb
    begin
        sel    = SEL_NONE;
        hi_sel = 1'b0;
        unique case (bus_addr)
            ADDR_TXV_HIGH:  begin sel = SEL_TXV;  hi_sel = 1'b1; end
            ADDR_TXV_LOW:   begin sel = SEL_TXV;  hi_sel = 1'b0; end
            ADDR_HOLD:      begin sel = SEL_HOLD; hi_sel = 1'b0; end
            ADDR_FLAGS:     begin sel = SEL_FLAGS; hi_sel = 1'b0; end
            ADDR_LCV_HIGH:  begin sel = SEL_LCV;  hi_sel = 1'b1; end
            ADDR_LCV_LOW:   begin sel = SEL_LCV;  hi_sel = 1'b0; end
            ADDR_PBIT_HIGH: begin sel = SEL_PBIT; hi_sel = 1'b1; end
            ADDR_PBIT_LOW:  begin sel = SEL_PBIT; hi_sel = 1'b0; end
            default:        begin sel = SEL_NONE; hi_sel = 1'b0; end
        endcase
    end

    always_comb
    begin
        unique case (sel)
            SEL_TXV:   sel_val = txv_cnt;
            SEL_LCV:   sel_val = lcv_acc_r;
            SEL_PBIT:  sel_val = pbit_acc_r;
            SEL_HOLD:  sel_val = {8'h00, hold_r};
            // Unused flag bits read as zero
            SEL_FLAGS: sel_val = {8'h00, 6'h00, es_r, ses_r};
            default:   sel_val = RST_DATA;
        endcase
    end

    always_comb
    begin
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = bus_rd;
        hold_nxt     = hold_r;
        if (bus_rd)
        begin
            if (sel == SEL_TXV || sel == SEL_LCV || sel == SEL_PBIT)
            begin
                if (bus_wide16)
                    rd_data_nxt = sel_val;
                else
                begin
                    // High address carries bits 15:8, companion bits 7:0
                    rd_data_nxt = {8'h00, hi_sel ? sel_val[15:8]
                                                 : sel_val[7:0]};
                    // Companion byte frozen so a later read is coherent
                    hold_nxt    = hi_sel ? sel_val[7:0]
                                         : sel_val[15:8];
                end
            end
            else
                rd_data_nxt = sel_val;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hold_r     <= RST_BYTE;
            rd_data_r  <= RST_DATA;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            hold_r     <= hold_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    txv_count_a: assert property (txv_inc && !txv_clr && txv_cnt != 16'hFFFF |=>
        txv_cnt == $past(txv_cnt) + 16'h0001)
        else $error("valid cell count did not advance");

    read_clear_a: assert property (txv_clr && !txv_inc |=> txv_cnt == 16'h0000)
        else $error("valid cell count not cleared by read");

    mode_gate_a: assert property (!atm_uni_mode && !txv_clr |=> $stable(txv_cnt))
        else $error("valid cell count moved outside ATM mode");

    hold_latch_a: assert property (bus_rd && !bus_wide16 && bus_addr == ADDR_LCV_LOW
        |=> hold_r == $past(lcv_acc_r[15:8]))
        else $error("hold register missed companion byte");

    es_flag_a: assert property (one_sec_tick |=> es_r ==
        ($past(lcv_run) != 16'h0000 || $past(pbit_run) != 16'h0000))
        else $error("errored second flag wrong");

    ses_flag_a: assert property (one_sec_tick |=> ses_r == ($past(err_total) > SES_ERR_LIMIT))
        else $error("severe errored second flag wrong");

    lcv_acc_a: assert property (one_sec_tick |=> lcv_acc_r == $past(lcv_run))
        else $error("line code violation accumulator wrong");

    pbit_acc_a: assert property (one_sec_tick |=> pbit_acc_r == $past(pbit_run))
        else $error("parity accumulator wrong");

    acc_hold_a: assert property (!one_sec_tick |=> $stable(lcv_acc_r) && $stable(pbit_acc_r))
        else $error("accumulator changed between boundaries");

    byte_lane_a: assert property (bus_rd && !bus_wide16 && bus_addr == ADDR_PBIT_HIGH
        |=> rd_valid_r && rd_data_r == {8'h00, $past(pbit_acc_r[15:8])})
        else $error("high byte on wrong lane");

    run_restart_a: assert property (one_sec_tick && !lcv_event && !pbit_error |=>
        lcv_run == 16'h0000 && pbit_run == 16'h0000)
        else $error("running count not restarted");

    flag_unused_a: assert property (bus_rd && bus_addr == ADDR_FLAGS |=>
        rd_data_r[15:2] == 14'h0000)
        else $error("unused flag bits not zero");

    tick_cov_c:  cover property (one_sec_tick ##1 es_r);
    ses_cov_c:   cover property (one_sec_tick ##1 ses_r);
    // Host leaves one idle cycle between reads, so the hold read lands two edges later
    read8_cov_c: cover property (bus_rd && !bus_wide16 && sel == SEL_TXV
                                 ##2 bus_rd && bus_addr == ADDR_HOLD);
    clrset_cov_c: cover property (txv_clr && txv_inc);

endmodule

// *** verification/pmsa_host.sv ***
// Host model: a processor issuing one register read at a time.
// Assumes the block answers one clock after it takes the read strobe.
`timescale 1ns/1ps
module pmsa_host
(
    input  wire logic        sys_clk,
    output logic      [7:0]  bus_addr,
    output logic             bus_rd,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    initial
    begin
        bus_addr = 8'h00;
        bus_rd   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe held across one taking edge; answer sampled a cycle later
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge sys_clk);
        bus_addr = a;
        bus_rd   = 1'b1;
        @(negedge sys_clk);
        bus_rd   = 1'b0;
        // Idle address inverted so a stale decode cannot pass unseen
        bus_addr = ~a;
        v        = rd_valid;
        d        = rd_data;
    endtask
endmodule

// *** verification/test_perf_monitor_second_accumulators.sv ***
// Testbench for the one-second accumulator and cell count registers.
// Assumes a host model for reads and drives all event strobes directly.
`timescale 1ns/1ps
module test_perf_monitor_second_accumulators
    import pmsa_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  bus_addr;
    logic        bus_rd;
    logic        bus_wide16 = 1'b0;
    logic        atm_uni_mode = 1'b0;
    logic        tx_valid_cell = 1'b0;
    logic        lcv_event = 1'b0;
    logic        pbit_error = 1'b0;
    logic        one_sec_tick = 1'b0;
    logic [15:0] rd_data;
    logic        rd_valid;
    int          err_count = 0;
    int          cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    pmsa_regs dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .bus_wide16(bus_wide16), .atm_uni_mode(atm_uni_mode), .tx_valid_cell(tx_valid_cell),
        .lcv_event(lcv_event), .pbit_error(pbit_error), .one_sec_tick(one_sec_tick),
        .rd_data(rd_data), .rd_valid(rd_valid));

    pmsa_host host (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
        .rd_data(rd_data), .rd_valid(rd_valid));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        host.rd(a, d, v);
        chk("rd_valid", {15'h0000, v}, 16'h0001);
        chk($sformatf("register %h", a), d, exp);
    endtask

    // Mask bits: 0 cell, 1 line violation, 2 parity; each high cycle is one event
    task automatic burst(input logic [2:0] m, input int n);
        @(negedge sys_clk);
        {pbit_error, lcv_event, tx_valid_cell} = m;
        repeat (n) @(negedge sys_clk);
        {pbit_error, lcv_event, tx_valid_cell} = 3'h0;
    endtask

    task automatic tick();
        @(negedge sys_clk);
        one_sec_tick = 1'b1;
        @(negedge sys_clk);
        one_sec_tick = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 8'h3A; a <= 8'h41; a++)
        begin
            rchk(8'(a), 16'h0000);
        end
        rchk(8'h50, 16'h0000);
    endtask

    task automatic t_txv();
        burst(3'h1, 3);
        rchk(ADDR_TXV_LOW, 16'h0000);
        atm_uni_mode = 1'b1;
        burst(3'h1, 291);
        rchk(ADDR_TXV_LOW, 16'h0023);
        rchk(ADDR_HOLD, 16'h0001);
        rchk(ADDR_TXV_LOW, 16'h0000);
        burst(3'h1, 2);
        rchk(ADDR_TXV_HIGH, 16'h0000);
        rchk(ADDR_HOLD, 16'h0002);
        burst(3'h1, 261);
        bus_wide16 = 1'b1;
        rchk(ADDR_TXV_LOW, 16'h0105);
        bus_wide16 = 1'b0;
        // A cell in the clearing read's cycle belongs to the next count
        tx_valid_cell = 1'b1;
        rchk(ADDR_TXV_LOW, 16'h0001);
        tx_valid_cell = 1'b0;
        rchk(ADDR_TXV_LOW, 16'h0001);
    endtask

    task automatic t_second();
        burst(3'h2, 5);
        burst(3'h4, 2);
        tick();
        rchk(ADDR_FLAGS, 16'h0002);
        rchk(ADDR_LCV_LOW, 16'h0005);
        rchk(ADDR_LCV_HIGH, 16'h0000);
        rchk(ADDR_HOLD, 16'h0005);
        rchk(ADDR_PBIT_LOW, 16'h0002);
        rchk(ADDR_PBIT_LOW, 16'h0002);
        bus_wide16 = 1'b1;
        rchk(ADDR_PBIT_HIGH, 16'h0002);
        bus_wide16 = 1'b0;
        tick();
        rchk(ADDR_FLAGS, 16'h0000);
        rchk(ADDR_LCV_LOW, 16'h0000);
    endtask

    // Threshold edge: 4473 errors is not severe, 4474 split over both sources is
    task automatic t_severe();
        burst(3'h2, 4473);
        tick();
        rchk(ADDR_FLAGS, 16'h0002);
        burst(3'h6, 474);
        burst(3'h2, 3526);
        tick();
        rchk(ADDR_FLAGS, 16'h0003);
        rchk(ADDR_LCV_HIGH, 16'h000F);
        rchk(ADDR_HOLD, 16'h00A0);
        rchk(ADDR_PBIT_LOW, 16'h00DA);
        rchk(ADDR_HOLD, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Run needs about 10000 cycles; three times that is a hang
    initial
    begin
        #3000000;
        err_count++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_txv();
        t_second();
        t_severe();
        end_sim();
    end
endmodule
